//--- ctl_byte_reg.sv
// One 8-bit control register with per-bit write mask and OTP reset load.
// Assumes the OTP value is stable while reset is held.
`timescale 1ns/1ps
`default_nettype none
module ctl_byte_reg #(
  parameter logic [7:0] WMASK = 8'hFF,
  parameter logic [7:0] OTPMASK = 8'h00
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] otp_value,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);
  import regulator_pkg::*;

  logic [7:0] q_r;
  logic [7:0] q_nxt;

  assign q_nxt = (q_r & ~WMASK) | (wr_data & WMASK);
  assign q = q_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q_r <= (otp_value & OTPMASK) | FIXED_RESET;
    end
    else if (wr_en)
    begin
      q_r <= q_nxt;
    end
  end

endmodule // ctl_byte_reg
`default_nettype wire

//--- regulator_control_regs.sv
// Regulator control register bank with Wishbone slave and mode logic.
// Assumes a classic Wishbone master and analog status inputs synchronous
// to clk.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Boost register bits 6:5 hold standby switching mode, off/PFM/auto/ALWAYS_PULSE_SWITCHING.
// - Boost bits 3:2 hold normal switching mode with the same encoding.
// - Boost bits 1:0 pick output voltage, 5.000 V plus 50 mV steps.
// - Auto mode picks PFM or always-pulse switching from the load current.
// - Start-up sequence enabling auto loads auto into the boost normal mode bits 3:2; standby mode keeps its OTP value.
// - Reference output register bit 0 enables that supply; resets to zero.
// - Backup supply bits 2:0 choose voltage; code 110 is the default.
// - Linear regulator bit 7 picks off or sleep after enable-pin turn-off.
// - Linear regulator bit 6 permits low-power mode under its conditions.
// - Linear regulator bit 5 turns it off during standby.
// - Linear regulator bit 4 enables the regulator.
// - Linear regulator bits 3:0 hold its output voltage code.
// - All registers may be read and written at any time.
// - OTP fields load at reset; unimplemented bits reset to zero.
module regulator_control_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [regulator_pkg::ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_wdata,
  output logic [31:0] wb_rdata,
  output logic wb_ack,
  input wire logic standby,
  input wire logic heavy_load,
  input wire logic pwr_en,
  input wire logic low_power_cond,
  input wire logic startup_auto,
  input wire logic [7:0] otp_boost_ctl,
  input wire logic [7:0] otp_backup_ctl,
  input wire logic [7:0] otp_linear_a_ctl,
  output regulator_pkg::boost_state_e boost_state,
  output logic [1:0] boost_voltage_code,
  output logic reference_output_enable,
  output logic [2:0] backup_supply_voltage_code,
  output regulator_pkg::lin_state_e linear_reg_a_state,
  output logic [3:0] linear_reg_a_voltage_code
);
  import regulator_pkg::*;

  // Index of a byte address matches a register
  function automatic logic addr_hit(
    input logic [ADR_W-1:0] adr,
    input logic [IDX_W-1:0] idx
  );
    addr_hit = (adr[ADR_W-1:2] == idx) && (adr[1:0] == 2'h0);
  endfunction

  // Switching mode to boost state
  function automatic boost_state_e boost_decode(
    input sw_mode_t mode,
    input logic heavy
  );
    boost_decode = BST_OFF;
    case (mode)
      MODE_OFF: boost_decode = BST_OFF;
      MODE_PFM: boost_decode = BST_PFM;
      MODE_AUTO: boost_decode = heavy ? BST_APS : BST_PFM;
      default: boost_decode = BST_APS;
    endcase
  endfunction

  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  boost_state_e boost_state_r;
  boost_state_e boost_state_nxt;
  lin_state_e lin_state_r;
  lin_state_e lin_state_nxt;

  logic [7:0] boost_q;
  logic [7:0] reference_output_supply_q;
  logic [7:0] backup_q;
  logic [7:0] lina_q;
  logic [7:0] boost_otp;

  wire take = wb_cyc && wb_stb && !ack_r;
  wire wr_lane = take && wb_we && wb_sel[0];
  wire hit_boost = addr_hit(wb_adr, IDX_BOOST);
  wire hit_reference_output_supply = addr_hit(wb_adr, IDX_REFERENCE_OUTPUT_SUPPLY);
  wire hit_backup = addr_hit(wb_adr, IDX_BACKUP);
  wire hit_lina = addr_hit(wb_adr, IDX_LINA);
  wire wr_boost = wr_lane && hit_boost;
  wire wr_reference_output_supply = wr_lane && hit_reference_output_supply;
  wire wr_backup = wr_lane && hit_backup;
  wire wr_lina = wr_lane && hit_lina;

  // Register read mux, unmapped addresses read zero
  wire [7:0] rd_byte =
    hit_boost ? boost_q :
    hit_reference_output_supply ? reference_output_supply_q :
    hit_backup ? backup_q :
    hit_lina ? lina_q : 8'h00;
  assign rdata_nxt = wb_we ? RDATA_RESET : {24'h00_0000, rd_byte};

  // Start-up sequence with auto enabled forces auto normal mode
  assign boost_otp = startup_auto ?
    {otp_boost_ctl[7:4], MODE_AUTO, otp_boost_ctl[1:0]} :
    otp_boost_ctl;

  // Field views
  wire sw_mode_t stby_mode = boost_q[BOOST_STBY_LSB+:2];
  wire sw_mode_t norm_mode = boost_q[BOOST_NORM_LSB+:2];
  wire sw_mode_t act_mode = standby ? stby_mode : norm_mode;
  wire lin_offb = lina_q[LINA_OFFB_BIT];
  wire lin_lpwr = lina_q[LINA_LPWR_BIT];
  wire lin_stby = lina_q[LINA_STBY_BIT];
  wire lin_en = lina_q[LINA_EN_BIT];

  assign boost_state_nxt = boost_decode(act_mode, heavy_load);

  // Linear regulator state selection
  always_comb
  begin
    if (!lin_en)
    begin
      lin_state_nxt = LIN_OFF;
    end
    else if (!pwr_en)
    begin
      lin_state_nxt = lin_offb ? LIN_SLEEP : LIN_OFF;
    end
    else if (standby && lin_stby)
    begin
      lin_state_nxt = LIN_OFF;
    end
    else if (lin_lpwr && low_power_cond)
    begin
      lin_state_nxt = LIN_LOWPWR;
    end
    else
    begin
      lin_state_nxt = LIN_ON;
    end
  end

  // Register storage, OTP fields loaded during reset
  ctl_byte_reg #(
    .WMASK(BOOST_WMASK),
    .OTPMASK(BOOST_OTPMASK)
  ) u_boost (
    .clk(clk),
    .srst(srst),
    .otp_value(boost_otp),
    .wr_en(wr_boost),
    .wr_data(wb_wdata[7:0]),
    .q(boost_q)
  );

  ctl_byte_reg #(
    .WMASK(REFERENCE_OUTPUT_SUPPLY_WMASK),
    .OTPMASK(REFERENCE_OUTPUT_SUPPLY_OTPMASK)
  ) u_reference_output_supply (
    .clk(clk),
    .srst(srst),
    .otp_value(FIXED_RESET),
    .wr_en(wr_reference_output_supply),
    .wr_data(wb_wdata[7:0]),
    .q(reference_output_supply_q)
  );

  ctl_byte_reg #(
    .WMASK(BACKUP_WMASK),
    .OTPMASK(BACKUP_OTPMASK)
  ) u_backup (
    .clk(clk),
    .srst(srst),
    .otp_value(otp_backup_ctl),
    .wr_en(wr_backup),
    .wr_data(wb_wdata[7:0]),
    .q(backup_q)
  );

  ctl_byte_reg #(
    .WMASK(LINA_WMASK),
    .OTPMASK(LINA_OTPMASK)
  ) u_lina (
    .clk(clk),
    .srst(srst),
    .otp_value(otp_linear_a_ctl),
    .wr_en(wr_lina),
    .wr_data(wb_wdata[7:0]),
    .q(lina_q)
  );

  // Bus answer: ack registered one cycle after the request, ack drops the cycle after
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_r <= 1'b0;
      rdata_r <= RDATA_RESET;
    end
    else
    begin
      ack_r <= take;
      if (take)
      begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // Regulator state registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      boost_state_r <= BST_OFF;
      lin_state_r <= LIN_OFF;
    end
    else
    begin
      boost_state_r <= boost_state_nxt;
      lin_state_r <= lin_state_nxt;
    end
  end

  assign wb_ack = ack_r;
  assign wb_rdata = rdata_r;
  assign boost_state = boost_state_r;
  assign boost_voltage_code = boost_q[BOOST_VOLT_LSB+:2];
  assign reference_output_enable = reference_output_supply_q[REFERENCE_OUTPUT_SUPPLY_EN_BIT];
  assign backup_supply_voltage_code = backup_q[BACKUP_VOLT_LSB+:3];
  assign linear_reg_a_state = lin_state_r;
  assign linear_reg_a_voltage_code = lina_q[LINA_VOLT_LSB+:4];

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_take;
    wb_cyc && wb_stb && !wb_ack;
  endsequence

  sequence s_answer;
    wb_ack ##1 !wb_ack;
  endsequence

  property p_handshake;
    s_take |=> s_answer;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("ack not given for one cycle after request");

  property p_stby_mode;
    !srst && standby && (stby_mode == MODE_APS) |=>
      boost_state == BST_APS;
  endproperty
  a_stby_mode: assert property (p_stby_mode)
    else $error("standby ALWAYS_PULSE_SWITCHING mode not applied");

  property p_norm_mode;
    !srst && !standby && (norm_mode == MODE_PFM) |=>
      boost_state == BST_PFM;
  endproperty
  a_norm_mode: assert property (p_norm_mode)
    else $error("normal PFM mode not applied");

  property p_auto;
    !srst && (act_mode == MODE_AUTO) |=>
      boost_state == ($past(heavy_load) ? BST_APS : BST_PFM);
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto mode picked wrong switching");

  property p_volt_write;
    wr_boost |=> boost_voltage_code == $past(wb_wdata[1:0]);
  endproperty
  a_volt_write: assert property (p_volt_write)
    else $error("boost voltage code not written");

  property p_reference_output_supply_reset;
    $fell(srst) |-> !reference_output_enable && reference_output_supply_q == 8'h00;
  endproperty
  a_reference_output_supply_reset: assert property (p_reference_output_supply_reset)
    else $error("reference output register not zero after reset");

  property p_otp_load;
    $fell(srst) |->
      backup_supply_voltage_code == $past(otp_backup_ctl[2:0]) &&
      lina_q == {3'h0, $past(otp_linear_a_ctl[4:0])};
  endproperty
  a_otp_load: assert property (p_otp_load)
    else $error("OTP values not loaded at reset");

  property p_startup_auto;
    $fell(srst) && $past(startup_auto) |-> norm_mode == MODE_AUTO;
  endproperty
  a_startup_auto: assert property (p_startup_auto)
    else $error("start-up auto mode not loaded");

  property p_backup_write;
    wr_backup ##1 s_answer |-> backup_supply_voltage_code ==
      $past(wb_wdata[2:0], 2);
  endproperty
  a_backup_write: assert property (p_backup_write)
    else $error("backup supply code not written");

  property p_sleep;
    lin_en && !pwr_en |=> linear_reg_a_state ==
      ($past(lin_offb) ? LIN_SLEEP : LIN_OFF);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("turn-off state wrong");

  property p_lowpwr;
    (linear_reg_a_state == LIN_LOWPWR) |->
      $past(lin_lpwr) && $past(low_power_cond);
  endproperty
  a_lowpwr: assert property (p_lowpwr)
    else $error("low-power entered without permission");

  property p_stby_off;
    lin_en && pwr_en && standby && lin_stby |=> linear_reg_a_state == LIN_OFF;
  endproperty
  a_stby_off: assert property (p_stby_off)
    else $error("linear regulator on in standby");

  property p_disable;
    !lin_en |=> linear_reg_a_state == LIN_OFF;
  endproperty
  a_disable: assert property (p_disable)
    else $error("linear regulator on while disabled");

  property p_lin_volt;
    wr_lina |=> linear_reg_a_voltage_code == $past(wb_wdata[3:0]);
  endproperty
  a_lin_volt: assert property (p_lin_volt)
    else $error("linear voltage code not written");

  property p_reserved;
    wb_ack |-> wb_rdata[31:8] == 24'h00_0000 && reference_output_supply_q[7:1] == 7'h00 &&
      backup_q[7:3] == 5'h00 && !boost_q[7] && !boost_q[4];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");

endmodule // regulator_control_regs
`default_nettype wire

//--- regulator_control_regs_tb.sv
// Self-checking testbench for the regulator control register bank.
// Assumes the bank answers classic Wishbone cycles and that its own
// assertions sit in the design files.
`timescale 1ns/1ps
`default_nettype none
module regulator_control_regs_tb;
  import regulator_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [ADR_W-1:0] wb_adr = '0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdata = 32'h0;
  logic [31:0] wb_rdata;
  logic wb_ack;
  logic standby = 1'b0;
  logic heavy_load = 1'b0;
  logic pwr_en = 1'b0;
  logic low_power_cond = 1'b0;
  logic startup_auto = 1'b0;
  logic [7:0] otp_boost_ctl = 8'h00;
  logic [7:0] otp_backup_ctl = 8'h00;
  logic [7:0] otp_linear_a_ctl = 8'h00;
  boost_state_e boost_state;
  logic [1:0] boost_voltage_code;
  logic reference_output_enable;
  logic [2:0] backup_supply_voltage_code;
  lin_state_e linear_reg_a_state;
  logic [3:0] linear_reg_a_voltage_code;
  int num_errors = 0;
  int cmp_count = 0;
  int i;
  logic [7:0] d;
  logic [7:0] m [4];
  logic [7:0] wm [4] = '{BOOST_WMASK, REFERENCE_OUTPUT_SUPPLY_WMASK, BACKUP_WMASK, LINA_WMASK};
  logic [8:0] ix [5] = '{IDX_BOOST, IDX_REFERENCE_OUTPUT_SUPPLY, IDX_BACKUP, IDX_LINA, 9'h067};

  regulator_control_regs DUT (
    .clk(clk), .srst(srst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata),
    .wb_rdata(wb_rdata), .wb_ack(wb_ack), .standby(standby),
    .heavy_load(heavy_load), .pwr_en(pwr_en),
    .low_power_cond(low_power_cond), .startup_auto(startup_auto),
    .otp_boost_ctl(otp_boost_ctl), .otp_backup_ctl(otp_backup_ctl),
    .otp_linear_a_ctl(otp_linear_a_ctl), .boost_state(boost_state),
    .boost_voltage_code(boost_voltage_code),
    .reference_output_enable(reference_output_enable),
    .backup_supply_voltage_code(backup_supply_voltage_code),
    .linear_reg_a_state(linear_reg_a_state),
    .linear_reg_a_voltage_code(linear_reg_a_voltage_code)
  );

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One classic cycle; index 4 is an unmapped word
  task automatic wb(input logic we, input int k, input logic [3:0] sel,
                    input logic [7:0] dat);
    int n;
    logic [31:0] q;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {ix[k], 2'b00};
    wb_sel <= sel;
    wb_wdata <= {24'($urandom), dat};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    chk({31'h0, wb_ack}, 32'h1);
    if (we && sel[0] && k < 4)
      m[k] = dat & wm[k];
    if (!we)
      chk(q, (k < 4) ? {24'h0, m[k]} : 32'h0);
  endtask

  task automatic chk_outs;
    logic [1:0] md;
    logic [2:0] bs;
    logic [3:0] ls;
    logic [7:0] r;
    repeat (2) @(posedge clk);
    md = standby ? m[0][6:5] : m[0][3:2];
    bs = (md == MODE_OFF) ? BST_OFF : (md == MODE_PFM) ? BST_PFM :
         (md == MODE_APS) ? BST_APS : (heavy_load ? BST_APS : BST_PFM);
    r = m[3];
    ls = !r[4] ? LIN_OFF : !pwr_en ? (r[7] ? LIN_SLEEP : LIN_OFF) :
         (standby && r[5]) ? LIN_OFF :
         (r[6] && low_power_cond) ? LIN_LOWPWR : LIN_ON;
    chk(32'(boost_state), 32'(bs));
    chk(32'(boost_voltage_code), 32'(m[0][1:0]));
    chk(32'(reference_output_enable), 32'(m[1][0]));
    chk(32'(backup_supply_voltage_code), 32'(m[2][2:0]));
    chk(32'(linear_reg_a_state), 32'(ls));
    chk(32'(linear_reg_a_voltage_code), 32'(m[3][3:0]));
  endtask

  task automatic do_reset(input logic sa);
    @(posedge clk);
    srst <= 1'b1;
    startup_auto <= sa;
    otp_boost_ctl <= 8'($urandom);
    otp_backup_ctl <= {5'($urandom), 3'h6};
    otp_linear_a_ctl <= 8'($urandom);
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    m[0] = otp_boost_ctl & 8'h6F;
    if (sa)
      m[0][3:2] = MODE_AUTO;
    m[1] = 8'h00;
    m[2] = otp_backup_ctl & 8'h07;
    m[3] = otp_linear_a_ctl & 8'h1F;
    for (int k = 0; k < 5; k++)
      wb(1'b0, k, 4'hF, 8'h00);
  endtask

  initial
  begin
    void'($urandom(5));
    do_reset(1'b0);
    chk_outs;
    for (int k = 0; k < 200; k++)
    begin
      i = $urandom % 5;
      d = 8'($urandom);
      if (i == 2)
        d[2:0] = 3'h6;
      wb(1'($urandom), i, 4'($urandom), d);
      {standby, heavy_load, pwr_en, low_power_cond} <= 4'($urandom);
      chk_outs;
    end
    for (int c = 0; c < 64; c++)
    begin
      wb(1'b1, 0, 4'h1, {1'b1, c[3:2], 1'b1, c[1:0], c[5:4]});
      standby <= c[4];
      heavy_load <= c[5];
      chk_outs;
      wb(1'b0, 0, 4'hF, 8'h00);
    end
    for (int c = 0; c < 128; c++)
    begin
      wb(1'b1, 3, 4'h1, {c[3:0], 4'($urandom)});
      {pwr_en, standby, low_power_cond} <= c[6:4];
      chk_outs;
    end
    do_reset(1'b1);
    chk_outs;
    wrap_up;
  end

  initial
  begin
    #500000;
    num_errors++;
    wrap_up;
  end
endmodule // regulator_control_regs_tb
`default_nettype wire

//--- regulator_pkg.sv
// Constants, field layout and state codes of the regulator control bank.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package regulator_pkg;

  // Register data and bus widths
  localparam int REG_W = 8;
  localparam int ADR_W = 11;
  localparam int IDX_W = 9;

  // Register indices; the byte address is four times the index
  localparam logic [8:0] IDX_BOOST = 9'h066;
  localparam logic [8:0] IDX_REFERENCE_OUTPUT_SUPPLY = 9'h06A;
  localparam logic [8:0] IDX_BACKUP = 9'h06B;
  localparam logic [8:0] IDX_LINA = 9'h06C;

  // Writable bits of each register
  localparam logic [7:0] BOOST_WMASK = 8'h6F;
  localparam logic [7:0] REFERENCE_OUTPUT_SUPPLY_WMASK = 8'h01;
  localparam logic [7:0] BACKUP_WMASK = 8'h07;
  localparam logic [7:0] LINA_WMASK = 8'hFF;

  // Bits loaded from one-time-programmable content at reset
  localparam logic [7:0] BOOST_OTPMASK = 8'h6F;
  localparam logic [7:0] REFERENCE_OUTPUT_SUPPLY_OTPMASK = 8'h00;
  localparam logic [7:0] BACKUP_OTPMASK = 8'h07;
  localparam logic [7:0] LINA_OTPMASK = 8'h1F;

  // Field positions
  localparam int BOOST_STBY_LSB = 5;
  localparam int BOOST_NORM_LSB = 2;
  localparam int BOOST_VOLT_LSB = 0;
  localparam int REFERENCE_OUTPUT_SUPPLY_EN_BIT = 0;
  localparam int BACKUP_VOLT_LSB = 0;
  localparam int LINA_OFFB_BIT = 7;
  localparam int LINA_LPWR_BIT = 6;
  localparam int LINA_STBY_BIT = 5;
  localparam int LINA_EN_BIT = 4;
  localparam int LINA_VOLT_LSB = 0;

  // Switching mode codes
  typedef logic [1:0] sw_mode_t;
  localparam sw_mode_t MODE_OFF = 2'h0;
  localparam sw_mode_t MODE_PFM = 2'h1;
  localparam sw_mode_t MODE_AUTO = 2'h2;
  localparam sw_mode_t MODE_APS = 2'h3;

  // Only legal backup supply voltage code (3.0 V)
  localparam logic [2:0] BACKUP_VOLT_3V0 = 3'h6;

  // Value of all bits not taken from OTP after reset
  localparam logic [7:0] FIXED_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    BST_OFF = 3'b001,
    BST_PFM = 3'b010,
    BST_APS = 3'b100
  } boost_state_e;

  typedef enum logic [3:0] {
    LIN_OFF = 4'b0001,
    LIN_ON = 4'b0010,
    LIN_SLEEP = 4'b0100,
    LIN_LOWPWR = 4'b1000
  } lin_state_e;

endpackage
